/* rtl/spi_flash_pkg.sv */
package spi_flash_pkg;

  // ------------------------------------------------------------
  // Command opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_ERASE32 = 8'h52;
  localparam logic [7:0] OP_ERASE64 = 8'hD8;
  localparam logic [7:0] OP_CHIP_A = 8'h60;
  localparam logic [7:0] OP_CHIP_B = 8'hC7;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID = 8'hAB;
  localparam logic [7:0] OP_MAKER_PART = 8'h90;
  localparam logic [7:0] OP_IDENT3 = 8'h9F;

  // ------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------
  localparam logic [5:0] OPCODE_END = 6'h08;
  localparam logic [5:0] ADDR_END = 6'h20;
  localparam int MEM_ADDR_W = 17;
  localparam int BLK32_LSB = 15;
  localparam int BLK64_LSB = 16;
  localparam logic SWAP_ID_BIT = 1'b1;

  // ------------------------------------------------------------
  // Status byte fields and reset values
  // ------------------------------------------------------------
  localparam int ST_BUSY_POS = 0;
  localparam int ST_UNLOCK_POS = 1;
  localparam int ST_PROT_LSB = 2;
  localparam logic UNLOCK_RST = 1'b0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLOCK_ERASE_US = 1000;
  localparam int ARRAY_ERASE_US = 4000;
  localparam int SLEEP_ENTRY_US = 3;
  localparam int WAKE_SHORT_US = 3;
  localparam int WAKE_ID_US = 2;
  localparam int BLOCK_ERASE_CYC_DEF =
    (BLOCK_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARRAY_ERASE_CYC_DEF =
    (ARRAY_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_SHORT_CYC =
    (WAKE_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_ID_CYC =
    (WAKE_ID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : spi_flash_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : pin_sync

/* rtl/cycle_timer.sv */
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 24
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic busy,
  output logic done
);
  logic [W-1:0] count;

  // Restart wins over a running count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) count <= '0;
    else if (start) count <= load;
    else if (count != '0) count <= count - 1'b1;
  end

  assign busy = count != '0;
  assign done = count == W'(1);
endmodule : cycle_timer

/* rtl/spi_flash_erase_powerdown_id.sv */
// Summary of operation
// - Opcode 52H: 32KB block erase; needs unlock latch, 3 address bytes.
// - Opcode D8H: 64KB block erase; needs unlock latch, 3 address bytes.
// - Any address inside the target block erases that whole block.
// - Block erase runs only if select rises after the last address bit.
// - Valid block erase starts a timed cycle, busy flag high throughout.
// - The unlock latch is cleared during every erase cycle.
// - A block erase aimed at a protected block is not executed.
// - Opcodes 60H and C7H are chip erase, select rising after the opcode.
// - Chip erase runs only when all three protect bits are zero.
// - Opcode B9H alone enters deep sleep after the entry delay.
// - In deep sleep every command but the wake opcode is ignored.
// - Deep sleep is refused while a write cycle runs, which carries on.
// - Power loss ends deep sleep; power-up comes up in standby.
// - Bare ABH wakes the part; commands taken after the short wake delay.
// - ABH with three dummy bytes repeats the part id, MSB first.
// - Wake through the id form accepts commands after the id wake delay.
// - ABH is ignored while the busy flag is set.
// - Opcode 90H with address zero returns maker id then part id.
// - Opcode 90H with address one returns part id first.
// - Opcode 9FH returns maker code, memory type, then capacity byte.
// - Opcode 9FH is not decoded while an erase cycle runs.
// - Status read 05H is answered in standby, also during erase; not while entering, in or waking from deep sleep.
`timescale 1ns/1ps
module spi_flash_erase_powerdown_id import spi_flash_pkg::*; #(
  parameter int CNT_W = 24,
  parameter int BLOCK_ERASE_CYC = BLOCK_ERASE_CYC_DEF,
  parameter int ARRAY_ERASE_CYC = ARRAY_ERASE_CYC_DEF,
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h21, // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h3C, // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h17 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  output logic so_pin,
  output logic so_oe,
  input wire logic [2:0] protect_level,
  output logic busy_flag,
  output logic write_unlock_latch,
  output logic deep_sleep,
  output logic cmd_ready,
  output logic erase_start,
  output logic erase_whole,
  output logic [MEM_ADDR_W-1:0] erase_base
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    s_awake, s_entering, s_asleep, s_waking
  } power_e;

  function automatic logic [MEM_ADDR_W-1:0] block_align(
    input logic [MEM_ADDR_W-1:0] a, input logic big);
    logic [MEM_ADDR_W-1:0] r;
    r = a;
    r[BLK32_LSB-1:0] = '0;
    if (big) r[BLK64_LSB-1] = 1'b0;
    return r;
  endfunction : block_align

  // Protection covers the top 32KB, top 64KB, or all of the array
  function automatic logic blk_protected(
    input logic [1:0] top_idx, input logic [2:0] bp);
    logic r;
    case (bp)
      3'h0: r = 1'b0;
      3'h1: r = top_idx == 2'h3;
      3'h2: r = top_idx[1];
      default: r = 1'b1;
    endcase
    return r;
  endfunction : blk_protected

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  logic [2:0] pins_s;
  logic cs_n_s, sclk_s, si_s;
  logic cs_d, sclk_d;

  // Idle levels at reset: select high, so no false edge after reset
  pin_sync #(.W(3), .RST(3'h4)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d({cs_n_pin, sclk_pin, si_pin}),
    .q(pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s = pins_s[0];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
  wire cs_rise = cs_n_s & ~cs_d;
  wire cs_fall = ~cs_n_s & cs_d;

  // ------------------------------------------------------------
  // Serial input
  // ------------------------------------------------------------
  logic [5:0] bit_cnt;
  logic [22:0] shift_in;
  logic [7:0] opcode;
  logic [23:0] addr;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= '0;
      shift_in <= '0;
    end else if (cs_fall || cs_rise) begin
      // Cleared at both ends so a stale count never reopens output
      bit_cnt <= '0;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[21:0], si_s};
      if (bit_cnt != 6'h3F) bit_cnt <= bit_cnt + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      opcode <= '0;
      addr <= '0;
    end else if (sclk_rise && bit_cnt == OPCODE_END - 6'h01) begin
      opcode <= {shift_in[6:0], si_s};
    end else if (sclk_rise && bit_cnt == ADDR_END - 6'h01) begin
      addr <= {shift_in, si_s};
    end
  end

  // ------------------------------------------------------------
  // Command decode at the end of a frame
  // ------------------------------------------------------------
  power_e st, next_st;
  logic erase_busy, delay_done;

  // Exact bit counts reject frames cut short or overrun
  wire have_op = bit_cnt == OPCODE_END;
  wire have_addr = bit_cnt == ADDR_END;
  wire awake = st == s_awake;
  wire sleepy = st == s_asleep || st == s_entering;
  wire is_blk = opcode == OP_ERASE32 || opcode == OP_ERASE64;
  wire is_big = opcode == OP_ERASE64;
  wire is_chip = opcode == OP_CHIP_A || opcode == OP_CHIP_B;
  wire [MEM_ADDR_W-1:0] blk_base =
    block_align(addr[MEM_ADDR_W-1:0], is_big);
  wire [1:0] top_idx = blk_base[MEM_ADDR_W-1:BLK32_LSB] | {1'b0, is_big};
  wire open_ok = cs_rise & awake & ~busy_flag;

  wire do_blk = open_ok & write_unlock_latch & is_blk & have_addr
    & ~blk_protected(top_idx, protect_level);
  wire do_chip = open_ok & write_unlock_latch & is_chip & have_op
    & protect_level == 3'h0;
  wire do_unlock = open_ok & opcode == OP_WRITE_UNLOCK & have_op;
  wire do_sleep = open_ok & opcode == OP_SLEEP & have_op;
  wire wake_any = cs_rise & sleepy & ~busy_flag
    & opcode == OP_WAKE_ID;
  wire do_wake_short = wake_any & have_op;
  wire do_wake_id = wake_any & bit_cnt >= ADDR_END;

  // ------------------------------------------------------------
  // Self-timed cycles
  // ------------------------------------------------------------
  wire [CNT_W-1:0] erase_load = do_chip ? CNT_W'(ARRAY_ERASE_CYC)
                                        : CNT_W'(BLOCK_ERASE_CYC);
  wire [CNT_W-1:0] delay_load =
    do_sleep ? CNT_W'(SLEEP_ENTRY_CYC) :
    do_wake_short ? CNT_W'(WAKE_SHORT_CYC) : CNT_W'(WAKE_ID_CYC);
  wire delay_go = do_sleep | do_wake_short | do_wake_id;

  cycle_timer #(.W(CNT_W)) u_erase_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(do_blk | do_chip),
    .load(erase_load),
    .busy(erase_busy),
    .done()
  );

  cycle_timer #(.W(CNT_W)) u_delay_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(delay_go),
    .load(delay_load),
    .busy(),
    .done(delay_done)
  );

  assign busy_flag = erase_busy;

  always_comb begin
    next_st = st;
    case (st)
      s_awake: if (do_sleep) next_st = s_entering;
      s_entering: begin
        if (do_wake_short || do_wake_id) next_st = s_waking;
        else if (delay_done) next_st = s_asleep;
      end
      s_asleep: if (delay_go) next_st = s_waking;
      s_waking: if (delay_done) next_st = s_awake;
      default: next_st = s_awake;
    endcase
  end

  // Reset stands for power-up and always lands in standby
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) st <= s_awake;
    else st <= next_st;
  end

  assign deep_sleep = st == s_asleep;
  assign cmd_ready = awake;

  // Latch drops the moment an erase is launched
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) write_unlock_latch <= UNLOCK_RST;
    else if (do_unlock) write_unlock_latch <= 1'b1;
    else if (do_blk || do_chip) write_unlock_latch <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      erase_start <= 1'b0;
      erase_whole <= 1'b0;
      erase_base <= '0;
    end else begin
      erase_start <= do_blk | do_chip;
      if (do_blk || do_chip) begin
        erase_whole <= do_chip;
        erase_base <= do_chip ? '0 : blk_base;
      end
    end
  end

  // ------------------------------------------------------------
  // Serial output
  // ------------------------------------------------------------
  logic [2:0] out_bit;
  logic [1:0] out_byte;

  wire [7:0] status_byte = {3'h0, protect_level, write_unlock_latch,
                            busy_flag};
  wire op_status = opcode == OP_STATUS & awake;
  wire op_id = opcode == OP_WAKE_ID & ~busy_flag
    & st != s_waking;
  wire op_pair = opcode == OP_MAKER_PART & awake;
  wire op_ident = opcode == OP_IDENT3 & awake & ~busy_flag;
  wire [5:0] data_start = (op_status | op_ident) ? OPCODE_END : ADDR_END;
  wire streaming = ~cs_n_s & (op_status | op_id | op_pair | op_ident)
    & bit_cnt >= data_start;
  wire [1:0] n_bytes = op_ident ? 2'h3 : op_pair ? 2'h2 : 2'h1;
  wire [1:0] next_byte = (out_byte + 2'h1 == n_bytes) ? 2'h0
                                                     : out_byte + 2'h1;
  wire swap = addr[0] == SWAP_ID_BIT;
  wire [7:0] cur_byte =
    op_status ? status_byte :
    op_id ? PART_ID :
    op_pair ? (((out_byte == 2'h0) ^ swap) ? MAKER_ID : PART_ID) :
    out_byte == 2'h0 ? MAKER_ID :
    out_byte == 2'h1 ? MEM_TYPE : CAPACITY;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_bit <= '0;
      out_byte <= '0;
      so_pin <= 1'b0;
    end else if (cs_fall) begin
      out_bit <= '0;
      out_byte <= '0;
    end else if (sclk_fall && streaming) begin
      so_pin <= cur_byte[3'h7 - out_bit];
      out_bit <= out_bit + 3'h1;
      if (out_bit == 3'h7) out_byte <= next_byte;
    end
  end

  assign so_oe = streaming;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_busy_hold;
    busy_flag [*8];
  endsequence

  sequence s_entering_hold;
    (st == s_entering) [*3];
  endsequence

  a_erase_needs_unlock: assert property (
    erase_start |-> $past(write_unlock_latch))
    else $error("erase started without unlock latch");

  a_erase_busy_hold: assert property (
    $rose(busy_flag) |-> erase_start ##0 s_busy_hold)
    else $error("busy flag not held after erase start");

  a_unlock_cleared: assert property (
    erase_start |-> !write_unlock_latch)
    else $error("unlock latch survived erase start");

  a_block_aligned: assert property (
    erase_start && !erase_whole |-> erase_base[BLK32_LSB-1:0] == '0)
    else $error("block erase base not aligned");

  a_chip_unprotected: assert property (
    erase_start && erase_whole |-> $past(protect_level) == 3'h0)
    else $error("chip erase with protection set");

  a_sleep_no_erase: assert property (
    deep_sleep |-> !erase_start && $stable(write_unlock_latch))
    else $error("write activity during deep sleep");

  a_busy_blocks_sleep: assert property (
    busy_flag && awake |=> st != s_entering)
    else $error("deep sleep taken during erase");

  a_sleep_entry: assert property (
    do_sleep |=> s_entering_hold ##0 !deep_sleep)
    else $error("deep sleep entered too early");

  a_wake_delay: assert property (
    $rose(cmd_ready) |-> $past(delay_done) && $past(st) == s_waking)
    else $error("commands accepted before wake delay");

  a_so_released: assert property (
    cs_d |-> !so_oe)
    else $error("output driven while deselected");

endmodule : spi_flash_erase_powerdown_id

/* dv/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  input wire logic ref_clk,
  input wire logic so_pin,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic si_pin
);

  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    si_pin = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : half

  // ------
  // Mode 0 frame, clock parked low between frames
  // ------
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrx,
                       output logic [31:0] rx);
    rx = '0;
    @(posedge ref_clk);
    #1;
    cs_n_pin = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx) begin
        si_pin = tx[ntx-1-i];
      end else begin
        si_pin = ~si_pin;
      end
      half();
      sclk_pin = 1'b1;
      // Mid high phase: output lags the pin edges by the synchronizer
      repeat (2) @(posedge ref_clk);
      #1;
      rx = {rx[30:0], so_pin};
      repeat (2) @(posedge ref_clk);
      #1;
      sclk_pin = 1'b0;
    end
    half();
    cs_n_pin = 1'b1;
    si_pin = ~si_pin;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : frame

endmodule : spi_host_model

/* dv/spi_flash_erase_powerdown_id_tb.sv */
`timescale 1ns/1ps
module spi_flash_erase_powerdown_id_tb import spi_flash_pkg::*;;
  localparam int BLK = 16;
  localparam int ARR = 2000;
  localparam logic [7:0] MK = 8'hA5; // Arbitrary value
  localparam logic [7:0] PT = 8'h4E; // Arbitrary value
  localparam logic [7:0] TY = 8'h61; // Arbitrary value
  localparam logic [7:0] CP = 8'h12; // Arbitrary value
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] adr;
    logic [2:0] bp;
    int n;
    logic ok;
    logic [MEM_ADDR_W-1:0] base;
  } ecase_s;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] protect_level = 3'h0;
  logic cs_n_pin, sclk_pin, si_pin, so_pin, so_oe;
  logic busy_flag, write_unlock_latch, deep_sleep, cmd_ready;
  logic erase_start, erase_whole;
  logic [MEM_ADDR_W-1:0] erase_base;
  logic [31:0] rx;
  logic oe_seen = 1'b0;
  int mismatches = 0;
  int tests_run = 0;
  int n_erase = 0;
  int busy_len = 0;
  int n0;
  ecase_s ec [12];

  always #25 ref_clk = ~ref_clk;

  spi_flash_erase_powerdown_id #(
    .BLOCK_ERASE_CYC(BLK), .ARRAY_ERASE_CYC(ARR),
    .MAKER_ID(MK), .PART_ID(PT), .MEM_TYPE(TY), .CAPACITY(CP)
  ) u_spi_flash_erase_powerdown_id (
    .ref_clk(ref_clk), .arst_n(arst_n), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .si_pin(si_pin), .so_pin(so_pin), .so_oe(so_oe),
    .protect_level(protect_level), .busy_flag(busy_flag),
    .write_unlock_latch(write_unlock_latch), .deep_sleep(deep_sleep),
    .cmd_ready(cmd_ready), .erase_start(erase_start),
    .erase_whole(erase_whole), .erase_base(erase_base)
  );

  spi_host_model u_spi_host_model (
    .ref_clk(ref_clk), .so_pin(so_pin), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .si_pin(si_pin)
  );

  // ------
  // Monitors
  // ------
  always @(posedge ref_clk) begin
    if (so_oe === 1'b1) oe_seen = 1'b1;
    if (erase_start === 1'b1) begin
      n_erase++;
      busy_len = 0;
    end
    if (busy_flag === 1'b1) busy_len++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xf(input logic [39:0] tx, input int ntx, input int nrx);
    u_spi_host_model.frame(tx, ntx, nrx, rx);
  endtask : xf

  task automatic cmd(input logic [7:0] op);
    xf({32'h0, op}, 8, 0);
  endtask : cmd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc

  task automatic wait_idle();
    for (int k = 0; k < 3000 && busy_flag !== 1'b0; k++) wait_cyc(1);
    chk(busy_flag, 1'b0);
  endtask : wait_idle

  task automatic sleep_now();
    cmd(OP_SLEEP);
    wait_cyc(40);
    chk(deep_sleep, 1'b0);
    wait_cyc(30);
    chk({deep_sleep, cmd_ready}, 2'b10);
  endtask : sleep_now

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #3_000_000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ------
  // Main sequence
  // ------
  initial begin
    ec = '{
      '{OP_ERASE32, 24'h01ABCD, 3'h0, 32, 1'b1, 17'h18000},
      '{OP_ERASE64, 24'h00FFFF, 3'h0, 32, 1'b1, 17'h00000},
      '{OP_ERASE64, 24'h01FFFF, 3'h0, 32, 1'b1, 17'h10000},
      '{OP_ERASE32, 24'h018000, 3'h1, 32, 1'b0, 17'h00000},
      '{OP_ERASE32, 24'h010000, 3'h1, 32, 1'b1, 17'h10000},
      '{OP_ERASE64, 24'h010000, 3'h1, 32, 1'b0, 17'h00000},
      '{OP_ERASE64, 24'h000000, 3'h1, 32, 1'b1, 17'h00000},
      '{OP_ERASE64, 24'h010000, 3'h2, 32, 1'b0, 17'h00000},
      '{OP_ERASE32, 24'h000000, 3'h3, 32, 1'b0, 17'h00000},
      '{OP_ERASE64, 24'h000000, 3'h0, 31, 1'b0, 17'h00000},
      '{OP_ERASE64, 24'h000000, 3'h0, 33, 1'b0, 17'h00000},
      '{OP_ERASE32, 24'h000000, 3'h0, 5, 1'b0, 17'h00000}};
    wait_cyc(12);
    arst_n = 1'b1;
    chk({busy_flag, write_unlock_latch, deep_sleep, cmd_ready, so_oe},
        5'b00010);
    wait_cyc(4);
    xf({8'h0, OP_ERASE32, 24'h01ABCD}, 32, 0);
    chk(n_erase, 0);
    cmd(OP_WRITE_UNLOCK);
    protect_level = 3'h5;
    xf({32'h0, OP_STATUS}, 8, 8);
    chk(rx[7:0], 8'h16);
    foreach (ec[i]) begin
      protect_level = ec[i].bp;
      cmd(OP_WRITE_UNLOCK);
      n0 = n_erase;
      xf({ec[i].op, ec[i].adr, 8'h0} >> (40 - ec[i].n), ec[i].n, 0);
      chk(n_erase, n0 + (ec[i].ok ? 1 : 0));
      if (ec[i].ok) begin
        chk({busy_flag, write_unlock_latch}, 2'b10);
        chk(erase_whole, 1'b0);
        chk(erase_base, ec[i].base);
        wait_idle();
        chk(busy_len, BLK);
      end
    end
    protect_level = 3'h1;
    cmd(OP_WRITE_UNLOCK);
    n0 = n_erase;
    cmd(OP_CHIP_A);
    chk(n_erase, n0);
    protect_level = 3'h0;
    for (int j = 0; j < 2; j++) begin
      cmd(OP_WRITE_UNLOCK);
      n0 = n_erase;
      cmd(j ? OP_CHIP_B : OP_CHIP_A);
      chk({busy_flag, write_unlock_latch, erase_whole}, 3'b101);
      chk(n_erase - n0 + erase_base, 1);
      if (j == 0) begin
        xf({32'h0, OP_STATUS}, 8, 8);
        chk(rx[7:0], 8'h01);
        cmd(OP_SLEEP);
        cmd(OP_WAKE_ID);
        oe_seen = 1'b0;
        xf({8'h0, OP_WAKE_ID, 24'h0}, 32, 8);
        xf({32'h0, OP_IDENT3}, 8, 24);
        chk({deep_sleep, cmd_ready}, 2'b01);
        chk({oe_seen, busy_flag}, 2'b01);
      end
      wait_idle();
      chk(busy_len, ARR);
    end
    oe_seen = 1'b0;
    xf({32'h0, OP_IDENT3}, 8, 24);
    chk(rx[23:0], {MK, TY, CP});
    chk(oe_seen, 1'b1);
    for (int j = 0; j < 2; j++) begin
      xf({8'h0, OP_MAKER_PART, 23'h0, j[0]}, 32, 16);
      chk(rx[15:0], j ? {PT, MK} : {MK, PT});
    end
    xf({8'h0, OP_WAKE_ID, 24'h0}, 32, 16);
    chk(rx[15:0], {PT, PT});
    oe_seen = 1'b0;
    // Status read and chip erase sent while asleep must be ignored
    sleep_now();
    xf({32'h0, OP_STATUS}, 8, 8);
    cmd(OP_WRITE_UNLOCK);
    n0 = n_erase;
    cmd(OP_CHIP_A);
    chk(oe_seen, 1'b0);
    chk(n_erase, n0);
    cmd(OP_WAKE_ID);
    wait_cyc(40);
    chk(cmd_ready, 1'b0);
    wait_cyc(30);
    chk({deep_sleep, cmd_ready}, 2'b01);
    sleep_now();
    xf({8'h0, OP_WAKE_ID, 24'h0}, 32, 8);
    chk(rx[7:0], PT);
    wait_cyc(20);
    chk(cmd_ready, 1'b0);
    wait_cyc(30);
    chk({deep_sleep, cmd_ready}, 2'b01);
    sleep_now();
    arst_n = 1'b0;
    wait_cyc(2);
    arst_n = 1'b1;
    chk({deep_sleep, cmd_ready}, 2'b01);
    report_and_stop();
  end

endmodule : spi_flash_erase_powerdown_id_tb
